// File: common/afmc_pkg.sv
/*
 * Constants shared by the add-on FIFO master control block.
 * Assumes one add-on bus clock drives every file that imports it.
 */
package afmc_pkg;
	// ------------------------------------------------------------
	// FIFO geometry
	// ------------------------------------------------------------
	localparam int DATA_W = 32;
	localparam int HALF_W = 16;
	localparam int LANES = 4;
	localparam int DEPTH = 8;
	localparam int PTR_W = 3;
	localparam int CNT_W = 4;
	localparam logic [CNT_W-1:0] FIFO_FULL_CNT = 4'h8;
	localparam logic [PTR_W-1:0] PTR_RESET = 3'h0;
	localparam logic [CNT_W-1:0] CNT_RESET = 4'h0;

	// ------------------------------------------------------------
	// Configuration byte loaded at initialisation
	// ------------------------------------------------------------
	localparam int CFG_W = 8;
	localparam int CFG_BM_ACCESS_BIT = 7;
	localparam int CFG_RD_STROBE_BIT = 6;
	localparam int CFG_WR_STROBE_BIT = 5;
	localparam int CFG_LATENCY_BIT = 0;
	localparam logic [CFG_W-1:0] CFG_RESET = 8'h80;

	// ------------------------------------------------------------
	// Add-on interrupt status bits
	// ------------------------------------------------------------
	localparam int INT_W = 3;
	localparam int INT_RD_ZERO = 0;
	localparam int INT_WR_ZERO = 1;
	localparam int INT_BM_ERROR = 2;
	localparam logic [INT_W-1:0] INT_RESET = 3'h0;

	// ------------------------------------------------------------
	// Half-word steering state
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		AFMC_HALF_LO = 2'b01,
		AFMC_HALF_HI = 2'b10
	} afmc_half_t;
endpackage

// File: rtl/afmc_fifo.sv
/*
 * Eight-word by 32-bit synchronous FIFO with synchronous clear.
 * Assumes push and pop come from logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module afmc_fifo (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic clr_i,
	input wire logic push_i,
	input wire logic [afmc_pkg::DATA_W-1:0] din_i,
	input wire logic pop_i,
	output logic [afmc_pkg::DATA_W-1:0] dout_o,
	output logic full_o,
	output logic empty_o
);
	import afmc_pkg::*;

	logic [DATA_W-1:0] mem [DEPTH];
	logic [PTR_W-1:0] wptr_r;
	logic [PTR_W-1:0] rptr_r;
	logic [CNT_W-1:0] cnt_r;
	logic push_ok;
	logic pop_ok;

	assign full_o = (cnt_r == FIFO_FULL_CNT);
	assign empty_o = (cnt_r == CNT_RESET);
	assign push_ok = push_i & ~full_o & ~clr_i;
	assign pop_ok = pop_i & ~empty_o & ~clr_i;
	assign dout_o = mem[rptr_r];

	always_ff @(posedge clk_i) begin
		if (push_ok) begin
			mem[wptr_r] <= din_i;
		end
	end

	// Clear zeroes pointers and count, so empty sets and full drops
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			wptr_r <= PTR_RESET;
			rptr_r <= PTR_RESET;
			cnt_r <= CNT_RESET;
		end else if (clr_i) begin
			wptr_r <= PTR_RESET;
			rptr_r <= PTR_RESET;
			cnt_r <= CNT_RESET;
		end else begin
			if (push_ok) begin
				wptr_r <= wptr_r + 3'h1;
			end
			if (pop_ok) begin
				rptr_r <= rptr_r + 3'h1;
			end
			if (push_ok && !pop_ok) begin
				cnt_r <= cnt_r + 4'h1;
			end else if (pop_ok && !push_ok) begin
				cnt_r <= cnt_r - 4'h1;
			end
		end
	end
endmodule
`default_nettype wire

// File: rtl/afmc_sync3.sv
/*
 * Three-stage input synchroniser with agreement filter.
 * Assumes the input may change at any time relative to clk_i.
 */
`timescale 1ns/1ps
`default_nettype none
module afmc_sync3 #(
	parameter logic RST_VAL = 1'b0
) (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic d_i,
	output logic q_o
);
	logic meta_r;
	logic s2_r;
	logic s3_r;
	logic q_r;

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			meta_r <= RST_VAL;
			s2_r <= RST_VAL;
			s3_r <= RST_VAL;
		end else begin
			meta_r <= d_i;
			s2_r <= meta_r;
			s3_r <= s2_r;
		end
	end

	// Output follows only once stages two and three agree
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			q_r <= RST_VAL;
		end else if (s2_r == s3_r) begin
			q_r <= s3_r;
		end
	end

	assign q_o = q_r;
endmodule
`default_nettype wire

// File: rtl/afmc_top.sv
/*
 * Add-on side control of the two bus-master FIFOs: enable and clear
 * inputs, extra flags, add-on interrupt, 16/32-bit packing and the
 * configuration byte captured at initialisation.
 * Assumes the add-on strobes and data are synchronous to REF_CLK_I, the
 * PCI master engine sits on the PCI_* ports on the same clock, and the
 * enable and clear lines may arrive asynchronously.
 */
`timescale 1ns/1ps
`default_nettype none
// Contract
// RULE1: Add-on drives master write enable high to permit bus master writes.
// RULE2: Add-on drives master read enable high to permit bus master reads.
// RULE3: Inbound clear low resets the PCI-to-add-on FIFO and flags.
// RULE4: Outbound clear low resets the add-on-to-PCI FIFO and flags.
// RULE5: Extra outputs show inbound full and outbound empty.
// RULE6: Enable inputs override PCI-side master enable bits, each FIFO alone.
// RULE7: Bus request only while that FIFO's enable is high; dropped otherwise.
// RULE8: Inbound prefetch may overrun by up to eight words.
// RULE9: Interrupt on read count zero, write count zero, or master error.
// RULE10: Interrupt shown by falling edge on shared active-low output.
// RULE11: Status read identifies source; clearing it returns output high.
// RULE12: Width select low gives 32-bit bus, high gives 16-bit bus.
// RULE13: In 16-bit mode top byte enable acts as address bit one.
// RULE14: Direct strobes in 16-bit mode pack two halves per FIFO word.
// RULE15: First 16-bit cycle uses low half; advance byte must be 2 or 3.
// RULE16: 16-bit write to full FIFO loses data yet toggles steering.
// RULE17: Add-on should gate direct strobes with full and empty flags.
// RULE18: 8-bit FIFO advances on byte 0, 16-bit unpacked on byte 1.
// RULE19: Register accesses in 16-bit mode alternate address bit one.
// RULE20: Without a loaded configuration byte FIFO operation stays off.
// RULE21: Config bit 7 places master registers add-on side or PCI side.
// RULE22: Config bits 6 and 5 must be 0 to enable strobed access.
// RULE23: Config bit 0 enables the target latency timeout.
// RULE24: Extra flags and control inputs work only in add-on mastering.
// RULE25: Enable and clear inputs are sampled on the add-on clock.
module afmc_top (
	input wire logic REF_CLK_I,
	input wire logic ARST_N_I,
	input wire logic NV_CFG_LOAD_I,
	input wire logic [afmc_pkg::CFG_W-1:0] NV_CFG_BYTE_I,
	input wire logic MASTER_WRITE_ENABLE_IN_I,
	input wire logic MASTER_READ_ENABLE_IN_I,
	input wire logic INBOUND_FIFO_CLEAR_N_I,
	input wire logic OUTBOUND_FIFO_CLEAR_N_I,
	input wire logic PCI_MASTER_CONTROL_REG_RD_EN_I,
	input wire logic PCI_MASTER_CONTROL_REG_WR_EN_I,
	input wire logic BUS_16_I,
	input wire logic [1:0] ADVANCE_BYTE_I,
	input wire logic DIRECT_FIFO_READ_N_I,
	input wire logic DIRECT_FIFO_WRITE_N_I,
	input wire logic REG_FIFO_SEL_N_I,
	input wire logic REG_RD_N_I,
	input wire logic REG_WR_N_I,
	input wire logic [afmc_pkg::LANES-1:0] BYTE_ENABLE_N_I,
	input wire logic [afmc_pkg::DATA_W-1:0] DQ_I,
	output logic [afmc_pkg::DATA_W-1:0] DQ_O,
	output logic DQ_OE_O,
	output logic INBOUND_EMPTY_FLAG_O,
	output logic OUTBOUND_FULL_FLAG_O,
	output logic INBOUND_FIFO_FULL_OUT_O,
	output logic OUTBOUND_FIFO_EMPTY_OUT_O,
	input wire logic RD_COUNT_ZERO_I,
	input wire logic WR_COUNT_ZERO_I,
	input wire logic BM_ERROR_I,
	input wire logic INT_EN_RD_I,
	input wire logic INT_EN_WR_I,
	input wire logic [afmc_pkg::INT_W-1:0] INT_CLEAR_I,
	output logic [afmc_pkg::INT_W-1:0] INT_STATUS_O,
	output logic IRQ_N_O,
	input wire logic PCI_IN_VALID_I,
	input wire logic [afmc_pkg::DATA_W-1:0] PCI_IN_DATA_I,
	output logic PCI_IN_READY_O,
	output logic PCI_OUT_VALID_O,
	output logic [afmc_pkg::DATA_W-1:0] PCI_OUT_DATA_O,
	input wire logic PCI_OUT_TAKE_I,
	output logic PCI_RD_REQ_O,
	output logic PCI_WR_REQ_O,
	output logic FIFO_ENABLED_O,
	output logic BM_REGS_ON_PCI_O,
	output logic TARGET_LATENCY_EN_O
);
	import afmc_pkg::*;

	// Lanes touched by one add-on access
	function automatic logic [LANES-1:0] lane_mask(input logic m16, input logic hi,
			input logic direct, input logic [LANES-1:0] be_n);
		if (m16) begin
			lane_mask = hi ? 4'hC : 4'h3;
		end else if (direct) begin
			lane_mask = 4'hF;
		end else begin
			lane_mask = ~be_n;
		end
	endfunction

	// ------------------------------------------------------------
	// Configuration byte
	// ------------------------------------------------------------
	logic cfg_loaded_r;
	logic [CFG_W-1:0] cfg_r;
	logic fifo_on;
	logic aoi_mode;
	logic rd_strobe_ok;
	logic wr_strobe_ok;

	// First load only; later loads ignored
	always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			cfg_loaded_r <= 1'b0;
			cfg_r <= CFG_RESET;
		end else if (NV_CFG_LOAD_I && !cfg_loaded_r) begin
			cfg_loaded_r <= 1'b1; // RULE21
			cfg_r <= NV_CFG_BYTE_I;
		end
	end

	assign fifo_on = cfg_loaded_r; // RULE20
	assign aoi_mode = fifo_on & ~cfg_r[CFG_BM_ACCESS_BIT]; // RULE24
	assign rd_strobe_ok = fifo_on & ~cfg_r[CFG_RD_STROBE_BIT]; // RULE22
	assign wr_strobe_ok = fifo_on & ~cfg_r[CFG_WR_STROBE_BIT];
	assign FIFO_ENABLED_O = fifo_on;
	assign BM_REGS_ON_PCI_O = cfg_r[CFG_BM_ACCESS_BIT]; // RULE21
	assign TARGET_LATENCY_EN_O = fifo_on & cfg_r[CFG_LATENCY_BIT]; // RULE23

	// ------------------------------------------------------------
	// Control input synchronisers
	// ------------------------------------------------------------
	logic mwr_en_s;
	logic mrd_en_s;
	logic in_clr_n_s;
	logic out_clr_n_s;

	afmc_sync3 #(.RST_VAL(1'b0)) u_sync_mwr (
		.clk_i(REF_CLK_I), .arst_n_i(ARST_N_I),
		.d_i(MASTER_WRITE_ENABLE_IN_I), .q_o(mwr_en_s)); // RULE25
	afmc_sync3 #(.RST_VAL(1'b0)) u_sync_mrd (
		.clk_i(REF_CLK_I), .arst_n_i(ARST_N_I),
		.d_i(MASTER_READ_ENABLE_IN_I), .q_o(mrd_en_s));
	afmc_sync3 #(.RST_VAL(1'b1)) u_sync_iclr (
		.clk_i(REF_CLK_I), .arst_n_i(ARST_N_I),
		.d_i(INBOUND_FIFO_CLEAR_N_I), .q_o(in_clr_n_s));
	afmc_sync3 #(.RST_VAL(1'b1)) u_sync_oclr (
		.clk_i(REF_CLK_I), .arst_n_i(ARST_N_I),
		.d_i(OUTBOUND_FIFO_CLEAR_N_I), .q_o(out_clr_n_s));

	logic in_clr;
	logic out_clr;
	logic rd_en_eff;
	logic wr_en_eff;

	assign in_clr = aoi_mode & ~in_clr_n_s; // RULE3
	assign out_clr = aoi_mode & ~out_clr_n_s; // RULE4
	// Add-on enables win over the PCI-side bits in add-on mastering
	assign rd_en_eff = aoi_mode ? mrd_en_s : PCI_MASTER_CONTROL_REG_RD_EN_I; // RULE6 RULE2
	assign wr_en_eff = aoi_mode ? mwr_en_s : PCI_MASTER_CONTROL_REG_WR_EN_I; // RULE6 RULE1

	// ------------------------------------------------------------
	// FIFOs
	// ------------------------------------------------------------
	logic in_push;
	logic in_pop;
	logic in_full;
	logic in_empty;
	logic [DATA_W-1:0] in_head;
	logic out_push;
	logic out_full;
	logic out_empty;
	logic [DATA_W-1:0] out_word;

	// Depth of eight bounds any read prefetch overrun
	afmc_fifo u_in_fifo (
		.clk_i(REF_CLK_I), .arst_n_i(ARST_N_I), .clr_i(in_clr),
		.push_i(in_push), .din_i(PCI_IN_DATA_I), .pop_i(in_pop),
		.dout_o(in_head), .full_o(in_full), .empty_o(in_empty)); // RULE8
	afmc_fifo u_out_fifo (
		.clk_i(REF_CLK_I), .arst_n_i(ARST_N_I), .clr_i(out_clr),
		.push_i(out_push), .din_i(out_word), .pop_i(PCI_OUT_VALID_O & PCI_OUT_TAKE_I),
		.dout_o(PCI_OUT_DATA_O), .full_o(out_full), .empty_o(out_empty));

	// ------------------------------------------------------------
	// PCI master side
	// ------------------------------------------------------------
	// Request follows the enable level, so it drops as soon as it falls
	assign PCI_RD_REQ_O = fifo_on & rd_en_eff & ~in_full; // RULE7
	assign PCI_WR_REQ_O = fifo_on & wr_en_eff & ~out_empty; // RULE7
	assign PCI_IN_READY_O = PCI_RD_REQ_O;
	assign in_push = PCI_IN_VALID_I & PCI_IN_READY_O;
	assign PCI_OUT_VALID_O = PCI_WR_REQ_O;

	// ------------------------------------------------------------
	// Flags
	// ------------------------------------------------------------
	assign INBOUND_EMPTY_FLAG_O = in_empty;
	assign OUTBOUND_FULL_FLAG_O = out_full;
	assign INBOUND_FIFO_FULL_OUT_O = aoi_mode & in_full; // RULE5 RULE24
	assign OUTBOUND_FIFO_EMPTY_OUT_O = aoi_mode & out_empty; // RULE5

	// ------------------------------------------------------------
	// Add-on write path
	// ------------------------------------------------------------
	afmc_half_t wr_half_r;
	logic dir_wr;
	logic reg_wr;
	logic wr_hi;
	logic [LANES-1:0] wr_lanes;
	logic [DATA_W-1:0] wr_place;
	logic [DATA_W-1:0] wr_hold_r;

	assign dir_wr = wr_strobe_ok & ~DIRECT_FIFO_WRITE_N_I;
	assign reg_wr = wr_strobe_ok & ~REG_FIFO_SEL_N_I & ~REG_WR_N_I & DIRECT_FIFO_WRITE_N_I;
	// Direct strobes steer internally; register access uses address bit one
	assign wr_hi = dir_wr ? (wr_half_r == AFMC_HALF_HI) : BYTE_ENABLE_N_I[LANES-1]; // RULE13
	assign wr_lanes = lane_mask(BUS_16_I, wr_hi, dir_wr, BYTE_ENABLE_N_I); // RULE12
	assign wr_place = BUS_16_I ? {DQ_I[HALF_W-1:0], DQ_I[HALF_W-1:0]} : DQ_I;

	always_comb begin
		out_word = wr_hold_r;
		for (int i = 0; i < LANES; i++) begin
			if (wr_lanes[i]) begin
				out_word[i*8 +: 8] = wr_place[i*8 +: 8];
			end
		end
	end

	// Word goes in when the advance lane is written; full drops it
	assign out_push = (dir_wr | reg_wr) & wr_lanes[ADVANCE_BYTE_I] & ~out_full; // RULE14 RULE18

	always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			wr_hold_r <= '0;
		end else if (out_clr) begin
			wr_hold_r <= '0;
		end else if (dir_wr | reg_wr) begin
			wr_hold_r <= out_word;
		end
	end

	// Steering toggles even when the write is lost to a full FIFO
	always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			wr_half_r <= AFMC_HALF_LO; // RULE15
		end else if (out_clr || !BUS_16_I) begin
			wr_half_r <= AFMC_HALF_LO;
		end else if (dir_wr) begin
			unique case (wr_half_r)
				AFMC_HALF_LO: wr_half_r <= AFMC_HALF_HI; // RULE16
				AFMC_HALF_HI: wr_half_r <= AFMC_HALF_LO;
				default: wr_half_r <= AFMC_HALF_LO;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Add-on read path
	// ------------------------------------------------------------
	afmc_half_t rd_half_r;
	logic dir_rd;
	logic reg_rd;
	logic rd_hi;
	logic [LANES-1:0] rd_lanes;
	logic [DATA_W-1:0] dq_r;
	logic dq_oe_r;

	assign dir_rd = rd_strobe_ok & ~DIRECT_FIFO_READ_N_I;
	assign reg_rd = rd_strobe_ok & ~REG_FIFO_SEL_N_I & ~REG_RD_N_I & DIRECT_FIFO_READ_N_I;
	assign rd_hi = dir_rd ? (rd_half_r == AFMC_HALF_HI) : BYTE_ENABLE_N_I[LANES-1]; // RULE13
	assign rd_lanes = lane_mask(BUS_16_I, rd_hi, dir_rd, BYTE_ENABLE_N_I);
	assign in_pop = (dir_rd | reg_rd) & rd_lanes[ADVANCE_BYTE_I]; // RULE14

	always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			dq_r <= '0;
			dq_oe_r <= 1'b0;
		end else begin
			dq_oe_r <= dir_rd | reg_rd;
			if (dir_rd | reg_rd) begin
				if (BUS_16_I) begin
					dq_r <= {16'h0000, rd_hi ? in_head[DATA_W-1:HALF_W] : in_head[HALF_W-1:0]};
				end else begin
					dq_r <= in_head; // RULE12
				end
			end
		end
	end

	assign DQ_O = dq_r;
	assign DQ_OE_O = dq_oe_r;

	// Empty reads still toggle steering, as writes do
	always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			rd_half_r <= AFMC_HALF_LO;
		end else if (in_clr || !BUS_16_I) begin
			rd_half_r <= AFMC_HALF_LO;
		end else if (dir_rd) begin
			unique case (rd_half_r)
				AFMC_HALF_LO: rd_half_r <= AFMC_HALF_HI;
				AFMC_HALF_HI: rd_half_r <= AFMC_HALF_LO;
				default: rd_half_r <= AFMC_HALF_LO;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Add-on interrupt
	// ------------------------------------------------------------
	logic [INT_W-1:0] int_status_r;
	logic [INT_W-1:0] int_set;

	assign int_set[INT_RD_ZERO] = aoi_mode & INT_EN_RD_I & RD_COUNT_ZERO_I; // RULE9
	assign int_set[INT_WR_ZERO] = aoi_mode & INT_EN_WR_I & WR_COUNT_ZERO_I;
	assign int_set[INT_BM_ERROR] = aoi_mode & (INT_EN_RD_I | INT_EN_WR_I) & BM_ERROR_I;

	// New event beats a clear in the same cycle
	always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			int_status_r <= INT_RESET;
		end else begin
			int_status_r <= (int_status_r & ~INT_CLEAR_I) | int_set; // RULE11
		end
	end

	assign INT_STATUS_O = int_status_r;
	assign IRQ_N_O = ~|int_status_r; // RULE10

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge REF_CLK_I); endclocking
	default disable iff (!ARST_N_I);

	sequence s_lo_wr16;
		BUS_16_I && dir_wr && wr_half_r == AFMC_HALF_LO && !out_clr;
	endsequence
	sequence s_hi_wr16;
		BUS_16_I && dir_wr && wr_half_r == AFMC_HALF_HI && !out_clr && !out_full;
	endsequence

	irq_assert_a: assert property ( // RULE9 RULE10
		(|int_set && IRQ_N_O) |=> !IRQ_N_O)
		else $error("interrupt output did not fall after event");
	irq_release_a: assert property ( // RULE11
		(!IRQ_N_O && ((int_status_r & ~INT_CLEAR_I) == INT_RESET) && !(|int_set)) |=> IRQ_N_O)
		else $error("interrupt output not released after clear");
	in_clear_a: assert property ( // RULE3
		in_clr |=> INBOUND_EMPTY_FLAG_O && !INBOUND_FIFO_FULL_OUT_O)
		else $error("inbound clear did not empty the FIFO");
	out_clear_a: assert property ( // RULE4
		out_clr |=> OUTBOUND_FIFO_EMPTY_OUT_O && !OUTBOUND_FULL_FLAG_O)
		else $error("outbound clear did not empty the FIFO");
	full_flag_a: assert property ( // RULE5
		INBOUND_FIFO_FULL_OUT_O |-> aoi_mode && !PCI_RD_REQ_O && !INBOUND_EMPTY_FLAG_O)
		else $error("inbound full output wrong");
	req_withdraw_a: assert property ( // RULE7
		$fell(mrd_en_s) && aoi_mode |-> !PCI_RD_REQ_O ##1 !PCI_RD_REQ_O)
		else $error("read request kept after enable dropped");
	enable_override_a: assert property ( // RULE6
		aoi_mode && PCI_MASTER_CONTROL_REG_WR_EN_I && !mwr_en_s |-> !PCI_WR_REQ_O)
		else $error("PCI enable bit overrode add-on enable");
	pack_low_a: assert property ( // RULE14
		(s_lo_wr16 and ADVANCE_BYTE_I[1]) |-> !out_push)
		else $error("low half pushed a FIFO word");
	pack_pair_a: assert property ( // RULE14
		s_lo_wr16 ##1 (s_hi_wr16 and ADVANCE_BYTE_I[1]) |-> out_push)
		else $error("second half did not push a FIFO word");
	steer_toggle_a: assert property ( // RULE16
		BUS_16_I && dir_wr && !out_clr ##1 BUS_16_I && !out_clr |-> wr_half_r != $past(wr_half_r))
		else $error("write steering failed to toggle");
	nv_off_a: assert property ( // RULE20
		!cfg_loaded_r |-> !PCI_RD_REQ_O && !PCI_WR_REQ_O && !out_push && !dq_oe_r)
		else $error("FIFO active without configuration");
	cfg_fixed_a: assert property ( // RULE21
		cfg_loaded_r |=> $stable(cfg_r) && cfg_loaded_r)
		else $error("configuration changed after load");
endmodule
`default_nettype wire

// File: verif/afmc_addon_model.sv
/*
 * Add-on card logic model that drives the direct FIFO strobes and data.
 * Assumes the bench changes its requests just after the rising clock edge.
 */
`timescale 1ns/1ps
`default_nettype none
module afmc_addon_model (
	input wire logic want_wr_i,
	input wire logic want_rd_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_full_i,
	input wire logic rd_empty_i,
	input wire logic reg_wr_n_i,
	output logic wr_n_o,
	output logic rd_n_o,
	output logic [31:0] dq_o
);
	// --------------------------------------------------------------
	// Strobes gated by flags
	// --------------------------------------------------------------
	assign wr_n_o = ~(want_wr_i & ~wr_full_i);
	assign rd_n_o = ~(want_rd_i & ~rd_empty_i);
	// Idle bus shows inverted data, never a stale word
	assign dq_o = (wr_n_o & reg_wr_n_i) ? ~wdata_i : wdata_i;
endmodule
`default_nettype wire

// File: verif/tb_top.sv
/*
 * Self-checking bench for the add-on FIFO master control block.
 * Assumes the add-on model gates direct strobes with the FIFO flags.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import afmc_pkg::*;
	logic clk, arst_n, ld, want_wr, want_rd, wr_n, rd_n, wen, ren, in_clr_n, out_clr_n;
	logic mrd, mwr, b16, in_v, take, oe, in_e, out_f, in_f, out_e, in_rdy, out_v;
	logic rreq, wreq, fen, bmp, lat, irq_n, sel_n, rdr_n, wrr_n;
	logic [7:0] cfg;
	logic [1:0] adv, ie;
	logic [3:0] be_n;
	logic [2:0] ev, iclr, ist;
	logic [31:0] wd, dq, din, dq_o, out_d;
	logic [15:0] lo, hi;
	logic [31:0] q[$];
	int n_fail, compares, i;

	afmc_top u_afmc_top (.REF_CLK_I(clk), .ARST_N_I(arst_n), .NV_CFG_LOAD_I(ld),
		.NV_CFG_BYTE_I(cfg), .MASTER_WRITE_ENABLE_IN_I(wen), .MASTER_READ_ENABLE_IN_I(ren),
		.INBOUND_FIFO_CLEAR_N_I(in_clr_n), .OUTBOUND_FIFO_CLEAR_N_I(out_clr_n),
		.PCI_MASTER_CONTROL_REG_RD_EN_I(mrd), .PCI_MASTER_CONTROL_REG_WR_EN_I(mwr), .BUS_16_I(b16), .ADVANCE_BYTE_I(adv),
		.DIRECT_FIFO_READ_N_I(rd_n), .DIRECT_FIFO_WRITE_N_I(wr_n), .REG_FIFO_SEL_N_I(sel_n),
		.REG_RD_N_I(rdr_n), .REG_WR_N_I(wrr_n), .BYTE_ENABLE_N_I(be_n), .DQ_I(dq),
		.DQ_O(dq_o), .DQ_OE_O(oe), .INBOUND_EMPTY_FLAG_O(in_e), .OUTBOUND_FULL_FLAG_O(out_f),
		.INBOUND_FIFO_FULL_OUT_O(in_f), .OUTBOUND_FIFO_EMPTY_OUT_O(out_e),
		.RD_COUNT_ZERO_I(ev[0]), .WR_COUNT_ZERO_I(ev[1]), .BM_ERROR_I(ev[2]),
		.INT_EN_RD_I(ie[0]), .INT_EN_WR_I(ie[1]), .INT_CLEAR_I(iclr), .INT_STATUS_O(ist),
		.IRQ_N_O(irq_n), .PCI_IN_VALID_I(in_v), .PCI_IN_DATA_I(din),
		.PCI_IN_READY_O(in_rdy), .PCI_OUT_VALID_O(out_v), .PCI_OUT_DATA_O(out_d),
		.PCI_OUT_TAKE_I(take), .PCI_RD_REQ_O(rreq), .PCI_WR_REQ_O(wreq),
		.FIFO_ENABLED_O(fen), .BM_REGS_ON_PCI_O(bmp), .TARGET_LATENCY_EN_O(lat));

	afmc_addon_model u_afmc_addon_model (.want_wr_i(want_wr), .want_rd_i(want_rd),
		.wdata_i(wd), .wr_full_i(out_f), .rd_empty_i(in_e), .reg_wr_n_i(wrr_n),
		.wr_n_o(wr_n), .rd_n_o(rd_n),
		.dq_o(dq));

	// --------------------------------------------------------------
	// Helpers
	// --------------------------------------------------------------
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#5;
	endtask

	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s exp %h got %h", s, e, g);
		end
	endtask

	task automatic report_and_stop;
		if (n_fail == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	function automatic logic [31:0] pack16(input logic [15:0] h, input logic [15:0] l);
		return {h, l};
	endfunction

	initial begin
		clk = 1'h0;
		forever #25 clk = ~clk;
	end

	initial begin
		step(3000);
		n_fail++;
		report_and_stop();
	end

	// --------------------------------------------------------------
	// Scenarios
	// --------------------------------------------------------------
	initial begin
		n_fail = 0;
		compares = 0;
		void'($urandom(81234));
		{arst_n, ld, want_wr, want_rd, wen, ren, mrd, mwr, b16, in_v, take} = 11'h0;
		{in_clr_n, out_clr_n} = 2'h3;
		{sel_n, rdr_n, wrr_n} = 3'h7;
		cfg = 8'h01;
		adv = 2'h3;
		ie = 2'h0;
		ev = 3'h0;
		iclr = 3'h0;
		wd = 32'h0;
		din = 32'h0;
		be_n = 4'($urandom);
		step(16);
		arst_n = 1'h1;
		step(1);
		chk("fifo_en", 32'h0, fen);
		ld = 1'h1;
		step(1);
		ld = 1'h0;
		chk("fifo_en", 32'h1, fen);
		chk("bm_on_pci", 32'h0, bmp);
		chk("latency", 32'h1, lat);
		cfg = 8'h80;
		ld = 1'h1;
		step(1);
		ld = 1'h0;
		chk("bm_on_pci", 32'h0, bmp);
		mwr = 1'h1;
		want_wr = 1'h1;
		for (i = 0; i < 10; i++) begin
			wd = $urandom;
			if (!out_f) q.push_back(wd);
			step(1);
		end
		want_wr = 1'h0;
		chk("out_full", 32'h1, out_f);
		chk("out_empty", 32'h0, out_e);
		chk("wr_req", 32'h0, wreq);
		wen = 1'h1;
		step(6);
		chk("wr_req", 32'h1, wreq);
		wen = 1'h0;
		step(6);
		chk("wr_req", 32'h0, wreq);
		wen = 1'h1;
		step(6);
		while (q.size() > 0) begin
			chk("out_data", q.pop_front(), out_d);
			take = 1'h1;
			step(1);
		end
		take = 1'h0;
		chk("out_empty", 32'h1, out_e);
		b16 = 1'h1;
		lo = 16'($urandom);
		hi = 16'($urandom);
		want_wr = 1'h1;
		wd = {16'h0, lo};
		step(1);
		wd = {16'h0, hi};
		step(1);
		want_wr = 1'h0;
		chk("packed", pack16(hi, lo), out_d);
		chk("out_valid", 32'h1, out_v);
		{sel_n, wrr_n} = 2'h0;
		be_n = 4'h7;
		lo = 16'($urandom);
		wd = {16'h0, lo};
		step(1);
		be_n = 4'hF;
		hi = 16'($urandom);
		wd = {16'h0, hi};
		step(1);
		{sel_n, wrr_n} = 2'h3;
		take = 1'h1;
		step(1);
		take = 1'h0;
		chk("reg_packed", pack16(hi, lo), out_d);
		b16 = 1'h0;
		adv = 2'h1;
		be_n = 4'hC;
		{sel_n, wrr_n} = 2'h0;
		wd = $urandom;
		step(1);
		{sel_n, wrr_n} = 2'h3;
		take = 1'h1;
		step(1);
		take = 1'h0;
		chk("low16", {16'h0, wd[15:0]}, {16'h0, out_d[15:0]});
		out_clr_n = 1'h0;
		step(6);
		chk("out_empty", 32'h1, out_e);
		out_clr_n = 1'h1;
		b16 = 1'h0;
		ren = 1'h1;
		step(6);
		in_v = 1'h1;
		for (i = 0; i < 12; i++) begin
			din = $urandom;
			if (in_rdy) q.push_back(din);
			step(1);
		end
		in_v = 1'h0;
		chk("in_full", 32'h1, in_f);
		chk("rd_req", 32'h0, rreq);
		ren = 1'h0;
		want_rd = 1'h1;
		step(1);
		chk("rd_data", q[0], dq_o);
		chk("rd_oe", 32'h1, oe);
		step(1);
		want_rd = 1'h0;
		chk("rd_data", q[1], dq_o);
		in_clr_n = 1'h0;
		step(6);
		chk("in_empty", 32'h1, in_e);
		in_clr_n = 1'h1;
		ie = 2'h3;
		for (i = 0; i < 3; i++) begin
			ev = 3'h1 << i;
			step(1);
			ev = 3'h0;
			chk("irq_n", 32'h0, irq_n);
			chk("int_status", 32'h1 << i, ist);
			iclr = 3'h1 << i;
			step(1);
			iclr = 3'h0;
			chk("irq_n", 32'h1, irq_n);
		end
		report_and_stop();
	end
endmodule
`default_nettype wire
